// File: logic/pfr_sequencer.sv
// Purpose: Power-fail and reset sequencer with pushbutton and low-battery outputs.
// Assumes: Comparator flags and straps are synchronous to clk; crystal level is sampled.
// Notes:   All delays are counted in crystal ticks, not in system clock cycles.
//
// Functional notes
// - Supply failure asserts both power-fail outputs at once.
// - Duration select low: reset asserts 9 ms into a continuing failure.
// - Duration select high: reset asserts 18 ms into a continuing failure.
// - Reset and power-fail stay asserted while the failure continues.
// - A failure shorter than the delay pulses power-fail but not reset.
// - Power-fail deasserts at once when the supply recovers.
// - Duration select low: reset held 95 ms after supply recovery.
// - Duration select high: reset held 190 ms after supply recovery.
// - Tolerance select picks the comparator trip band.
// - Low pushbutton level is a request, debounced internally.
// - Pushbutton gives a reset pulse of 95 ms or 190 ms.
// - Pushbutton pulse timing starts at button release.
// - Reset and power-fail are complementary pairs; low-battery is complementary only while the supply is good.
// - All delays derive from the 32.768 kHz crystal time base.
// - Low battery with good supply asserts low-battery until battery recovers.
// - Supply below trip point drives both low-battery outputs low.
`timescale 1ns/10ps
`include "pfr_map.svh"

module pfr_sequencer #(
    parameter int ASSERT_SHORT_TICKS = `PFR_ASSERT_SHORT_TICKS,
    parameter int ASSERT_LONG_TICKS  = `PFR_ASSERT_LONG_TICKS,
    parameter int HOLD_SHORT_TICKS   = `PFR_HOLD_SHORT_TICKS,
    parameter int HOLD_LONG_TICKS    = `PFR_HOLD_LONG_TICKS,
    parameter int DEBOUNCE_TICKS     = `PFR_DEBOUNCE_TICKS
) (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          crystal_clock_in,
    input  wire logic          supply_fail,
    input  wire logic          battery_fail,
    input  wire logic          supply_margin_select,
    input  wire logic          duration_select,
    input  wire logic          manual_reset_n,
    output logic               crystal_clock_out,
    output pfr_pkg::pfr_trip_t trip_level_select,
    output pfr_pkg::pfr_pair_t power_fail_out,
    output pfr_pkg::pfr_pair_t reset_out,
    output pfr_pkg::pfr_pair_t low_battery_out
);

    // ======================================================================
    // Elaboration checks
    // Each count must fit the shared elapsed counter, or its last value would be truncated and the delay would end early.
    if (ASSERT_SHORT_TICKS < 1 || ASSERT_SHORT_TICKS >= (1 << `PFR_CNT_W)) begin
        $error("pfr_sequencer: ASSERT_SHORT_TICKS out of range");
    end
    if (ASSERT_LONG_TICKS < 1 || ASSERT_LONG_TICKS >= (1 << `PFR_CNT_W)) begin
        $error("pfr_sequencer: ASSERT_LONG_TICKS out of range");
    end
    if (HOLD_SHORT_TICKS < 1 || HOLD_SHORT_TICKS >= (1 << `PFR_CNT_W)) begin
        $error("pfr_sequencer: HOLD_SHORT_TICKS out of range");
    end
    if (HOLD_LONG_TICKS < 1 || HOLD_LONG_TICKS >= (1 << `PFR_CNT_W)) begin
        $error("pfr_sequencer: HOLD_LONG_TICKS out of range");
    end

    localparam logic [`PFR_CNT_W-1:0] ASSERT_SHORT_LAST = `PFR_CNT_W'(ASSERT_SHORT_TICKS - 1);
    localparam logic [`PFR_CNT_W-1:0] ASSERT_LONG_LAST  = `PFR_CNT_W'(ASSERT_LONG_TICKS - 1);
    localparam logic [`PFR_CNT_W-1:0] HOLD_SHORT_LAST   = `PFR_CNT_W'(HOLD_SHORT_TICKS - 1);
    localparam logic [`PFR_CNT_W-1:0] HOLD_LONG_LAST    = `PFR_CNT_W'(HOLD_LONG_TICKS - 1);

    // ======================================================================
    // Declarations
    logic                  xtal_now;
    logic                  xtal_prev;
    logic                  next_xtal_now;
    logic                  next_xtal_prev;
    logic                  tick;
    logic                  button_pressed;
    pfr_pkg::pfr_state_t   state;
    pfr_pkg::pfr_state_t   next_state;
    logic [`PFR_CNT_W-1:0] elapsed;
    logic [`PFR_CNT_W-1:0] next_elapsed;
    logic [`PFR_CNT_W-1:0] assert_last;
    logic [`PFR_CNT_W-1:0] hold_last;
    logic                  assert_done;
    logic                  hold_done;
    logic                  next_reset_active;
    logic                  reset_active;
    logic                  power_fail_active;
    logic                  next_power_fail_active;
    pfr_pkg::pfr_pair_t    next_low_battery;
    pfr_pkg::pfr_trip_t    next_trip;

    // ======================================================================
    // Crystal time base
    always_comb begin
        next_xtal_now  = crystal_clock_in;
        next_xtal_prev = xtal_now;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            xtal_now  <= 1'b0;
            xtal_prev <= 1'b0;
        end else begin
            xtal_now  <= next_xtal_now;
            xtal_prev <= next_xtal_prev;
        end
    end

    // One tick per rising crystal edge; every delay below counts these.
    assign tick              = xtal_now & ~xtal_prev;
    assign crystal_clock_out = xtal_now;

    // ======================================================================
    // Pushbutton debounce
    pfr_debounce #(
        .STABLE_TICKS (DEBOUNCE_TICKS)
    ) pfr_debounce_i (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .tick     (tick),
        .button_n (manual_reset_n),
        .pressed  (button_pressed)
    );

    // ======================================================================
    // Duration selection
    always_comb begin
        assert_last = duration_select ? ASSERT_LONG_LAST : ASSERT_SHORT_LAST;
        hold_last   = duration_select ? HOLD_LONG_LAST : HOLD_SHORT_LAST;
        assert_done = tick && (elapsed == assert_last);
        hold_done   = tick && (elapsed == hold_last);
    end

    // ======================================================================
    // Sequencer
    always_comb begin
        next_state   = state;
        next_elapsed = tick ? elapsed + `PFR_CNT_W'(1) : elapsed;
        case (state)
            pfr_pkg::PFR_ST_RUN: begin
                next_elapsed = '0;
                if (supply_fail) begin
                    next_state = pfr_pkg::PFR_ST_FAIL_WAIT;
                end else if (button_pressed) begin
                    next_state = pfr_pkg::PFR_ST_BUTTON;
                end
            end
            pfr_pkg::PFR_ST_FAIL_WAIT: begin
                if (!supply_fail) begin
                    // Brief dip: reset is never touched.
                    next_state   = pfr_pkg::PFR_ST_RUN;
                    next_elapsed = '0;
                end else if (assert_done) begin
                    next_state   = pfr_pkg::PFR_ST_FAIL_RESET;
                    next_elapsed = '0;
                end
            end
            pfr_pkg::PFR_ST_FAIL_RESET: begin
                next_elapsed = '0;
                if (!supply_fail) begin
                    next_state = pfr_pkg::PFR_ST_HOLD;
                end
            end
            pfr_pkg::PFR_ST_HOLD: begin
                if (supply_fail) begin
                    next_state   = pfr_pkg::PFR_ST_FAIL_RESET;
                    next_elapsed = '0;
                end else if (button_pressed) begin
                    next_state   = pfr_pkg::PFR_ST_BUTTON;
                    next_elapsed = '0;
                end else if (hold_done) begin
                    next_state   = pfr_pkg::PFR_ST_RUN;
                    next_elapsed = '0;
                end
            end
            pfr_pkg::PFR_ST_BUTTON: begin
                next_elapsed = '0;
                if (supply_fail) begin
                    next_state = pfr_pkg::PFR_ST_FAIL_RESET;
                end else if (!button_pressed) begin
                    // Pulse is timed from release, so a long press never cuts it short.
                    next_state = pfr_pkg::PFR_ST_HOLD;
                end
            end
            default: begin
                next_state   = pfr_pkg::PFR_ST_HOLD;
                next_elapsed = '0;
            end
        endcase
    end

    always_comb begin
        case (next_state)
            pfr_pkg::PFR_ST_FAIL_RESET: next_reset_active = 1'b1;
            pfr_pkg::PFR_ST_HOLD:       next_reset_active = 1'b1;
            pfr_pkg::PFR_ST_BUTTON:     next_reset_active = 1'b1;
            default:                    next_reset_active = 1'b0;
        endcase
    end

    // Reset starts in the hold state, so power-up gives the full release delay.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state        <= pfr_pkg::PFR_ST_HOLD;
            elapsed      <= '0;
            reset_active <= 1'b1;
        end else begin
            state        <= next_state;
            elapsed      <= next_elapsed;
            reset_active <= next_reset_active;
        end
    end

    // ======================================================================
    // Power-fail, low-battery and trip band
    always_comb begin
        // Follows the comparator with no counted delay in either direction.
        next_power_fail_active = supply_fail;
        if (supply_fail) begin
            next_low_battery.active   = 1'b0;
            next_low_battery.active_n = 1'b0;
        end else begin
            next_low_battery.active   = battery_fail;
            next_low_battery.active_n = ~battery_fail;
        end
        next_trip = supply_margin_select ? pfr_pkg::PFR_TRIP_LOW_BAND
                                         : pfr_pkg::PFR_TRIP_HIGH_BAND;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            power_fail_active <= 1'b0;
            low_battery_out   <= '{active: 1'b0, active_n: 1'b1};
            trip_level_select <= pfr_pkg::PFR_TRIP_HIGH_BAND;
        end else begin
            power_fail_active <= next_power_fail_active;
            low_battery_out   <= next_low_battery;
            trip_level_select <= next_trip;
        end
    end

    // ======================================================================
    // Complementary outputs
    always_comb begin
        power_fail_out.active   = power_fail_active;
        power_fail_out.active_n = ~power_fail_active;
        reset_out.active        = reset_active;
        reset_out.active_n      = ~reset_active;
    end

endmodule : pfr_sequencer

// File: inc/pfr_map.svh
// Purpose: Timing constants for the power-fail and reset sequencer.
// Assumes: Time base is the 32.768 kHz crystal, seen as ticks on the system clock.
// Notes:   Every count is in crystal ticks; least times round up.
`ifndef PFR_MAP_SVH
`define PFR_MAP_SVH

// ==========================================================================
// Time base
`define PFR_XTAL_HZ          32768
`define PFR_SYS_CLK_MHZ      125
`define PFR_CNT_W            13

// ==========================================================================
// Times in milliseconds, as documented
`define PFR_ASSERT_SHORT_MS  9
`define PFR_ASSERT_LONG_MS   18
`define PFR_HOLD_SHORT_MS    95
`define PFR_HOLD_LONG_MS     190
`define PFR_DEBOUNCE_MS      10

// ==========================================================================
// Times in crystal ticks, rounded up
`define PFR_MS_TO_TICKS(ms)  (((ms) * `PFR_XTAL_HZ + 999) / 1000)
`define PFR_ASSERT_SHORT_TICKS `PFR_MS_TO_TICKS(`PFR_ASSERT_SHORT_MS)
`define PFR_ASSERT_LONG_TICKS  `PFR_MS_TO_TICKS(`PFR_ASSERT_LONG_MS)
`define PFR_HOLD_SHORT_TICKS   `PFR_MS_TO_TICKS(`PFR_HOLD_SHORT_MS)
`define PFR_HOLD_LONG_TICKS    `PFR_MS_TO_TICKS(`PFR_HOLD_LONG_MS)
`define PFR_DEBOUNCE_TICKS     `PFR_MS_TO_TICKS(`PFR_DEBOUNCE_MS)

`endif

// File: inc/pfr_pkg.sv
// Purpose: Types shared by the power-fail and reset sequencer.
// Assumes: Nothing beyond the map header.
// Notes:   Complementary outputs travel as one pair.
package pfr_pkg;

    // ======================================================================
    // Complementary output pair
    typedef struct packed {
        logic active;
        logic active_n;
    } pfr_pair_t;

    // ======================================================================
    // Comparator trip level selection
    typedef enum logic {
        PFR_TRIP_HIGH_BAND,
        PFR_TRIP_LOW_BAND
    } pfr_trip_t;

    // ======================================================================
    // Sequencer states
    typedef enum logic [2:0] {
        PFR_ST_RUN,
        PFR_ST_FAIL_WAIT,
        PFR_ST_FAIL_RESET,
        PFR_ST_HOLD,
        PFR_ST_BUTTON
    } pfr_state_t;

endpackage : pfr_pkg

// File: logic/pfr_debounce.sv
// Purpose: Debounce of the pushbutton input on crystal ticks.
// Assumes: Input is synchronous to clk; tick is a one-cycle pulse.
// Notes:   Output changes only after the input held a new level for STABLE_TICKS ticks.
`timescale 1ns/10ps
`include "pfr_map.svh"

module pfr_debounce #(
    parameter int STABLE_TICKS = `PFR_DEBOUNCE_TICKS
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic tick,
    input  wire logic button_n,
    output logic      pressed
);

    // A count that does not fit the counter would have its last value truncated, so it would end early.
    if (STABLE_TICKS < 1 || STABLE_TICKS >= (1 << `PFR_CNT_W)) begin
        $error("pfr_debounce: STABLE_TICKS out of range");
    end

    localparam logic [`PFR_CNT_W-1:0] LAST = `PFR_CNT_W'(STABLE_TICKS - 1);

    logic [`PFR_CNT_W-1:0] count;
    logic [`PFR_CNT_W-1:0] next_count;
    logic                  next_pressed;

    // ======================================================================
    // Stability counter
    always_comb begin
        next_count   = count;
        next_pressed = pressed;
        if (~button_n == pressed) begin
            next_count = '0;
        end else if (tick) begin
            if (count == LAST) begin
                // A bounce restarts the count, so chatter never reaches the sequencer.
                next_pressed = ~button_n;
                next_count   = '0;
            end else begin
                next_count = count + `PFR_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count   <= '0;
            pressed <= 1'b0;
        end else begin
            count   <= next_count;
            pressed <= next_pressed;
        end
    end

endmodule : pfr_debounce

// File: tb/pfr_sva.sv
// Purpose: Port-level assertions for the power-fail and reset sequencer.
// Assumes: One clock domain; synchronous active-high reset.
// Notes:   Timed counts are left to the bench, apart from the 8-cycle quiet reset window after a failure starts.
`timescale 1ns/10ps

module pfr_sva (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               crystal_clock_in,
    input wire logic               supply_fail,
    input wire logic               battery_fail,
    input wire logic               supply_margin_select,
    input wire logic               crystal_clock_out,
    input wire pfr_pkg::pfr_trip_t trip_level_select,
    input wire pfr_pkg::pfr_pair_t power_fail_out,
    input wire pfr_pkg::pfr_pair_t reset_out,
    input wire pfr_pkg::pfr_pair_t low_battery_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ======================================================================
    // Sequences
    sequence fail_start;
        !reset_out.active ##0 $rose(supply_fail);
    endsequence

    sequence quiet_reset;
        !reset_out.active [*8];
    endsequence

    // ======================================================================
    // Properties
    AST_PF_SET: assert property (supply_fail |=> power_fail_out == 2'b10)
        else $error("power fail not raised after supply fail");
    AST_PF_CLR: assert property (!supply_fail |=> !power_fail_out.active)
        else $error("power fail not cleared after supply recovery");
    AST_PF_PAIR: assert property (power_fail_out.active_n != power_fail_out.active)
        else $error("power fail pair not complementary");
    AST_RST_PAIR: assert property (reset_out.active_n != reset_out.active)
        else $error("reset pair not complementary");
    AST_RST_STAYS: assert property (supply_fail && reset_out.active |=> reset_out.active)
        else $error("reset dropped during supply failure");
    AST_RST_LATE: assert property (fail_start |=> quiet_reset)
        else $error("reset raised without assert delay");
    AST_LB_GND: assert property (supply_fail |=> low_battery_out == 2'b00)
        else $error("low battery pair not grounded in supply failure");
    AST_LB_SET: assert property (!supply_fail && battery_fail |=> low_battery_out == 2'b10)
        else $error("low battery not raised");
    AST_LB_CLR: assert property (!supply_fail && !battery_fail |=> low_battery_out == 2'b01)
        else $error("low battery not cleared");
    AST_TRIP: assert property (1'b1 |=>
        trip_level_select == pfr_pkg::pfr_trip_t'($past(supply_margin_select)))
        else $error("trip band does not follow strap");
    AST_XTAL: assert property ($rose(crystal_clock_in) |=> $rose(crystal_clock_out))
        else $error("crystal output does not follow time base");
endmodule : pfr_sva

bind pfr_sequencer pfr_sva pfr_sva_i (
    .clk,
    .sys_rst,
    .crystal_clock_in,
    .supply_fail,
    .battery_fail,
    .supply_margin_select,
    .crystal_clock_out,
    .trip_level_select,
    .power_fail_out,
    .reset_out,
    .low_battery_out
);

// File: tb/pfr_host_model.sv
// Purpose: Processor-side reset logic that sits behind the reset pair.
// Assumes: Reset pair sampled on clk.
// Notes:   Records how many cycles the last reset pulse lasted.
`timescale 1ns/10ps

module pfr_host_model (
    input  wire logic               clk,
    input  wire pfr_pkg::pfr_pair_t reset_out,
    output logic [15:0]             reset_len
);
    logic [15:0] count = 16'h0000;
    logic [15:0] len   = 16'h0000;

    assign reset_len = len;

    // The host only sees a whole pulse once reset is let go.
    always @(posedge clk) begin
        if (reset_out.active) begin
            count <= count + 16'h0001;
        end else if (count != 16'h0000) begin
            len       <= count;
            count     <= 16'h0000;
        end
    end
endmodule : pfr_host_model

// File: tb/test_power_fail_reset_sequencer.sv
// Purpose: Self-checking bench for the power-fail and reset sequencer.
// Assumes: Short tick counts; one crystal tick every 8 clocks.
// Notes:   Timed checks allow a tick early and two ticks late, as phase to the crystal varies.
`timescale 1ns/10ps

module test_power_fail_reset_sequencer;
    localparam int TK = 8;

    logic               clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               crystal_clock_in = 1'b0;
    logic               supply_fail = 1'b0;
    logic               battery_fail = 1'b0;
    logic               supply_margin_select = 1'b0;
    logic               duration_select = 1'b0;
    logic               manual_reset_n = 1'b1;
    logic               crystal_clock_out;
    pfr_pkg::pfr_trip_t trip_level_select;
    pfr_pkg::pfr_pair_t power_fail_out;
    pfr_pkg::pfr_pair_t reset_out;
    pfr_pkg::pfr_pair_t low_battery_out;
    logic [15:0]        reset_len;
    logic [1:0]         xcnt = 2'h0;
    logic [7:0]         rnd = 8'h57;
    int                 n_errors = 0;
    int                 compares = 0;
    int                 cycles = 0;
    int                 n;

    pfr_sequencer #(
        .ASSERT_SHORT_TICKS(3), .ASSERT_LONG_TICKS(5), .HOLD_SHORT_TICKS(8),
        .HOLD_LONG_TICKS(12), .DEBOUNCE_TICKS(2)
    ) pfr_sequencer_i (
        .clk(clk), .sys_rst(sys_rst), .crystal_clock_in(crystal_clock_in),
        .supply_fail(supply_fail), .battery_fail(battery_fail),
        .supply_margin_select(supply_margin_select), .duration_select(duration_select),
        .manual_reset_n(manual_reset_n), .crystal_clock_out(crystal_clock_out),
        .trip_level_select(trip_level_select), .power_fail_out(power_fail_out),
        .reset_out(reset_out), .low_battery_out(low_battery_out)
    );

    pfr_host_model pfr_host_model_i (.clk(clk), .reset_out(reset_out), .reset_len(reset_len));

    always #4 clk = ~clk;

    // ======================================================================
    // Crystal ticks and hang guard
    always @(posedge clk) begin
        xcnt <= xcnt + 2'h1;
        if (xcnt == 2'h3) crystal_clock_in <= ~crystal_clock_in;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end

    // ======================================================================
    // Helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    function automatic int hold_clk(input logic d);
        return (d ? 12 : 8) * TK;
    endfunction : hold_clk

    function automatic int assert_clk(input logic d);
        return (d ? 5 : 3) * TK;
    endfunction : assert_clk

    function automatic logic near(input int got, input int exp);
        return got >= exp - TK && got <= exp + 2 * TK;
    endfunction : near

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic settle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : settle

    // A bounded wait, so a stuck reset cannot hang the run.
    task automatic wait_rst(input logic lvl, output int k);
        k = 0;
        while (reset_out.active !== lvl && k < 400) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 400) n_errors++;
    endtask : wait_rst

    task automatic complete_run();
        if (n_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run

    // ======================================================================
    // Scenarios
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        wait_rst(1'b0, n);
        check(near(n, hold_clk(1'b0)), 8'h01);
        settle(2);
        check(near(int'(reset_len), hold_clk(1'b0) + 3), 8'h01);
        @(posedge clk) supply_fail <= 1'b1;
        settle(1);
        check(power_fail_out, 8'h02);
        settle(1);
        check(low_battery_out, 8'h00);
        @(posedge clk) supply_fail <= 1'b0;
        settle(1);
        check(power_fail_out, 8'h01);
        settle(40);
        check(reset_out, 8'h01);
        for (int d = 0; d < 2; d++) begin
            rnd = lfsr(rnd);
            @(posedge clk) begin
                duration_select      <= d[0];
                supply_margin_select <= d[0];
                supply_fail          <= 1'b1;
                battery_fail         <= rnd[0];
            end
            wait_rst(1'b1, n);
            check(near(n, assert_clk(d[0])), 8'h01);
            check(trip_level_select, {7'h00, d[0]});
            settle(60 + int'(rnd[7:2]));
            check({reset_out, power_fail_out}, 8'h0A);
            @(posedge clk) supply_fail <= 1'b0;
            settle(1);
            check(power_fail_out, 8'h01);
            wait_rst(1'b0, n);
            check(near(n + 1, hold_clk(d[0])), 8'h01);
        end
        rnd = lfsr(rnd);
        @(posedge clk) begin
            duration_select <= rnd[2];
            battery_fail    <= 1'b0;
            manual_reset_n  <= 1'b0;
        end
        @(posedge clk) manual_reset_n <= 1'b1;
        settle(60);
        check(reset_out, 8'h01);
        @(posedge clk) manual_reset_n <= 1'b0;
        wait_rst(1'b1, n);
        check(near(n, 2 * TK), 8'h01);
        settle(40 + int'(rnd[7:3]));
        check(reset_out, 8'h02);
        @(posedge clk) supply_fail <= 1'b1;
        settle(30);
        check({reset_out, power_fail_out}, 8'h0A);
        @(posedge clk) begin
            supply_fail    <= 1'b0;
            manual_reset_n <= 1'b1;
        end
        wait_rst(1'b0, n);
        check(near(n, 2 * TK + hold_clk(rnd[2])), 8'h01);
        @(posedge clk) battery_fail <= 1'b1;
        settle(1);
        check(low_battery_out, 8'h02);
        @(posedge clk) battery_fail <= 1'b0;
        settle(1);
        check(low_battery_out, 8'h01);
        complete_run();
    end
endmodule : test_power_fail_reset_sequencer
